// file: logic/exec_group_defines.vh
// Operation codes, flag positions and timing counts for the skip/sub/xor execution group
`ifndef EXEC_GROUP_DEFINES_VH
`define EXEC_GROUP_DEFINES_VH

// ==========================================================
// Operation select codes
`define OP_NONE                   5'h00
`define OP_DECREMENT_SKIP         5'h01
`define OP_DECREMENT_TO_ACC_SKIP  5'h02
`define OP_SET_BYTE               5'h03
`define OP_SET_BIT                5'h04
`define OP_INCREMENT_SKIP_ON_WRAP 5'h05
`define OP_INCREMENT_TO_ACC_SKIP  5'h06
`define OP_BIT_SET_SKIP           5'h07
`define OP_MINUS_ACC              5'h08
`define OP_MINUS_STORE_MEM        5'h09
`define OP_MINUS_IMM              5'h0a
`define OP_NIBBLE_EXCHANGE        5'h0b
`define OP_NIBBLE_EXCHANGE_TO_ACC 5'h0c
`define OP_MEM_NIL_SKIP           5'h0d
`define OP_COPY_TO_ACC_NIL_SKIP   5'h0e
`define OP_BIT_CLEAR_SKIP         5'h0f
`define OP_ROM_FETCH_CURRENT_PAGE 5'h10
`define OP_ROM_FETCH_FINAL_PAGE   5'h11
`define OP_EXCLUSIVE_OR_ACC       5'h12
`define OP_EXCLUSIVE_OR_INTO_MEM  5'h13
`define OP_EXCLUSIVE_OR_IMM       5'h14

// ==========================================================
// Flag bit positions in the flag vector
`define FLAG_CARRY     0
`define FLAG_AUX_CARRY 1
`define FLAG_ZERO      2
`define FLAG_OVERFLOW  3
`define FLAG_POWER_DN  4
`define FLAG_TIME_OUT  5

// ==========================================================
// Reset values and timing
`define ACC_RESET      8'h00
`define FLAGS_RESET    6'h00
`define UPPER_RESET    8'h00
`define ALL_ONES_BYTE  8'hff
`define CYCLES_NORMAL  2'h1
`define CYCLES_SKIP    2'h2

`endif

// file: logic/sub_adder8.v
// Eight-bit adder with carry, half carry and overflow outputs
`timescale 1ns/1ps
`default_nettype none

module sub_adder8 (
  input  wire [7:0] a_in,
  input  wire [7:0] b_in,
  input  wire       carry_in,
  output wire [7:0] sum_out,
  output wire       carry_out,
  output wire       aux_carry_out,
  output wire       overflow_out
);
  // ==========================================================
  // Low nibble first so the half carry is explicit
  wire [4:0] low;
  wire [4:0] high;

  assign low           = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
  assign high          = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, low[4]};
  assign sum_out       = {high[3:0], low[3:0]};
  assign carry_out     = high[4];
  assign aux_carry_out = low[4];
  // Signed overflow: equal operand signs, different result sign
  assign overflow_out  = (a_in[7] == b_in[7]) && (high[3] != a_in[7]);
endmodule // sub_adder8

`default_nettype wire

// file: logic/exec_skip_sub_xor.v
// Execution unit for the skip, set, subtract, nibble-exchange, table-read and XOR group
`timescale 1ns/1ps
`default_nettype none
`include "exec_group_defines.vh"

module exec_skip_sub_xor #(
  parameter ROM_ADDR_WIDTH = 15,
  parameter PAGE_BITS      = 7
) (
  input  wire                      clock_in,
  input  wire                      rst_in,
  input  wire                      exec_valid_in,
  input  wire [4:0]                op_select_in,
  input  wire [7:0]                mem_data_in,
  input  wire [2:0]                bit_select_in,
  input  wire [7:0]                literal_in,
  input  wire [7:0]                rom_read_pointer_in,
  input  wire [ROM_ADDR_WIDTH-1:0] program_counter_in,
  input  wire [15:0]               rom_word_in,
  input  wire                      flag_time_out_in,
  input  wire                      flag_power_down_in,
  output reg  [7:0]                acc_out,
  output reg  [5:0]                flags_out,
  output reg  [7:0]                mem_wdata_out,
  output reg                       mem_write_out,
  output reg  [7:0]                rom_upper_byte_latch_out,
  output wire [ROM_ADDR_WIDTH-1:0] rom_addr_out,
  output reg                       rom_read_out,
  output reg                       discard_prefetch_out,
  output wire                      busy_out,
  output reg  [1:0]                cycles_out
);
  // ==========================================================
  // Table-read addressing
  wire                 table_final;
  wire [PAGE_BITS-1:0] page_cur;

  assign table_final = (op_select_in == `OP_ROM_FETCH_FINAL_PAGE);
  // Page field is the PC bits above the pointer byte; ROM_ADDR_WIDTH is PAGE_BITS plus 8
  assign page_cur    = program_counter_in[ROM_ADDR_WIDTH-1:ROM_ADDR_WIDTH-PAGE_BITS];
  // The pointer picks the word within the page; page comes from PC or is forced to all ones
  assign rom_addr_out = table_final ? {{PAGE_BITS{1'b1}}, rom_read_pointer_in}
                                    : {page_cur, rom_read_pointer_in};

  // ==========================================================
  // Shared subtract path: a + ~b + 1
  wire [7:0] sub_operand;
  wire [7:0] sub_sum;
  wire       sub_carry;
  wire       sub_aux;
  wire       sub_ovf;

  assign sub_operand = (op_select_in == `OP_MINUS_IMM) ? literal_in : mem_data_in;

  sub_adder8 subtractor (
    .a_in          (acc_out),
    .b_in          (~sub_operand),
    .carry_in      (1'b1),
    .sum_out       (sub_sum),
    .carry_out     (sub_carry),
    .aux_carry_out (sub_aux),
    .overflow_out  (sub_ovf)
  );

  // ==========================================================
  // Operand helpers
  wire [7:0] mem_dec;
  wire [7:0] mem_inc;
  wire [7:0] mem_swapped;
  wire [7:0] xor_mem;
  wire [7:0] xor_imm;
  wire [7:0] bit_mask;
  wire       sel_bit;

  assign mem_dec     = mem_data_in - 8'h01;
  assign mem_inc     = mem_data_in + 8'h01;
  assign mem_swapped = {mem_data_in[3:0], mem_data_in[7:4]};
  assign xor_mem     = acc_out ^ mem_data_in;
  assign xor_imm     = acc_out ^ literal_in;
  assign bit_mask    = 8'h01 << bit_select_in;
  assign sel_bit     = mem_data_in[bit_select_in];

  // ==========================================================
  // Per-operation results
  reg [7:0] next_acc;
  reg [5:0] next_flags;
  reg [7:0] next_mem;
  reg       next_mem_write;
  reg       next_upper_write;
  reg       next_skip;
  reg       next_rom_read;

  always @* begin
    next_acc         = acc_out;
    next_flags       = {flag_time_out_in, flag_power_down_in, flags_out[3:0]};
    next_mem         = mem_data_in;
    next_mem_write   = 1'b0;
    next_upper_write = 1'b0;
    next_skip        = 1'b0;
    next_rom_read    = 1'b0;
    case (op_select_in)
      `OP_DECREMENT_SKIP: begin
        next_mem       = mem_dec;
        next_mem_write = 1'b1;
        next_skip      = (mem_dec == 8'h00);
      end
      `OP_DECREMENT_TO_ACC_SKIP: begin
        next_acc  = mem_dec;
        next_skip = (mem_dec == 8'h00);
      end
      `OP_SET_BYTE: begin
        next_mem       = `ALL_ONES_BYTE;
        next_mem_write = 1'b1;
      end
      `OP_SET_BIT: begin
        next_mem       = mem_data_in | bit_mask;
        next_mem_write = 1'b1;
      end
      `OP_INCREMENT_SKIP_ON_WRAP: begin
        next_mem       = mem_inc;
        next_mem_write = 1'b1;
        next_skip      = (mem_inc == 8'h00);
      end
      `OP_INCREMENT_TO_ACC_SKIP: begin
        next_acc  = mem_inc;
        next_skip = (mem_inc == 8'h00);
      end
      `OP_BIT_SET_SKIP: begin
        next_skip = sel_bit;
      end
      `OP_MINUS_ACC, `OP_MINUS_IMM: begin
        next_acc = sub_sum;
        next_flags[`FLAG_OVERFLOW]  = sub_ovf;
        next_flags[`FLAG_ZERO]      = (sub_sum == 8'h00);
        next_flags[`FLAG_AUX_CARRY] = sub_aux;
        next_flags[`FLAG_CARRY]     = sub_carry;
      end
      `OP_MINUS_STORE_MEM: begin
        next_mem       = sub_sum;
        next_mem_write = 1'b1;
        next_flags[`FLAG_OVERFLOW]  = sub_ovf;
        next_flags[`FLAG_ZERO]      = (sub_sum == 8'h00);
        next_flags[`FLAG_AUX_CARRY] = sub_aux;
        next_flags[`FLAG_CARRY]     = sub_carry;
      end
      `OP_NIBBLE_EXCHANGE: begin
        next_mem       = mem_swapped;
        next_mem_write = 1'b1;
      end
      `OP_NIBBLE_EXCHANGE_TO_ACC: begin
        next_acc = mem_swapped;
      end
      `OP_MEM_NIL_SKIP: begin
        next_skip = (mem_data_in == 8'h00);
      end
      `OP_COPY_TO_ACC_NIL_SKIP: begin
        next_acc  = mem_data_in;
        next_skip = (mem_data_in == 8'h00);
      end
      `OP_BIT_CLEAR_SKIP: begin
        next_skip = ~sel_bit;
      end
      `OP_ROM_FETCH_CURRENT_PAGE, `OP_ROM_FETCH_FINAL_PAGE: begin
        next_mem         = rom_word_in[7:0];
        next_mem_write   = 1'b1;
        next_upper_write = 1'b1;
        next_rom_read    = 1'b1;
      end
      `OP_EXCLUSIVE_OR_ACC: begin
        next_acc = xor_mem;
        next_flags[`FLAG_ZERO] = (xor_mem == 8'h00);
      end
      `OP_EXCLUSIVE_OR_INTO_MEM: begin
        next_mem       = xor_mem;
        next_mem_write = 1'b1;
        next_flags[`FLAG_ZERO] = (xor_mem == 8'h00);
      end
      `OP_EXCLUSIVE_OR_IMM: begin
        next_acc = xor_imm;
        next_flags[`FLAG_ZERO] = (xor_imm == 8'h00);
      end
      default: begin
        next_acc = acc_out;
      end
    endcase
  end

  // ==========================================================
  // Dummy cycle after a taken skip
  reg dummy;
  wire accept;

  // A request during the dummy cycle is refused, not stored; it is taken only if exec_valid_in stays high into the next cycle
  assign busy_out = dummy;
  assign accept   = exec_valid_in & ~dummy;

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      acc_out                  <= `ACC_RESET;
      flags_out                <= `FLAGS_RESET;
      mem_wdata_out            <= 8'h00;
      mem_write_out            <= 1'b0;
      rom_upper_byte_latch_out <= `UPPER_RESET;
      rom_read_out             <= 1'b0;
      discard_prefetch_out     <= 1'b0;
      dummy                    <= 1'b0;
      cycles_out               <= 2'h0;
    end else begin
      flags_out[`FLAG_TIME_OUT] <= flag_time_out_in;
      flags_out[`FLAG_POWER_DN] <= flag_power_down_in;
      mem_write_out        <= 1'b0;
      rom_read_out         <= 1'b0;
      discard_prefetch_out <= 1'b0;
      dummy                <= 1'b0;
      if (accept) begin
        acc_out         <= next_acc;
        flags_out[3:0]  <= next_flags[3:0];
        mem_wdata_out   <= next_mem;
        mem_write_out   <= next_mem_write;
        rom_read_out    <= next_rom_read;
        if (next_upper_write) begin
          rom_upper_byte_latch_out <= rom_word_in[15:8];
        end
        discard_prefetch_out <= next_skip;
        dummy                <= next_skip;
        cycles_out <= next_skip ? `CYCLES_SKIP : `CYCLES_NORMAL;
      end
    end
  end
endmodule // exec_skip_sub_xor

`default_nettype wire

// file: testbench/exec_group_checker.sv
// Concurrent assertions on the ports of the execution group
`timescale 1ns/1ps
`default_nettype none
`include "exec_group_defines.vh"
module exec_group_checker #(
  parameter ROM_ADDR_WIDTH = 15
) (
  input wire logic                      clock_in,
  input wire logic                      rst_in,
  input wire logic                      exec_valid_in,
  input wire logic [4:0]                op_select_in,
  input wire logic [7:0]                mem_data_in,
  input wire logic [2:0]                bit_select_in,
  input wire logic [7:0]                rom_read_pointer_in,
  input wire logic [7:0]                acc_out,
  input wire logic [5:0]                flags_out,
  input wire logic [7:0]                mem_wdata_out,
  input wire logic                      mem_write_out,
  input wire logic [ROM_ADDR_WIDTH-1:0] rom_addr_out,
  input wire logic                      discard_prefetch_out,
  input wire logic                      busy_out,
  input wire logic [1:0]                cycles_out
);
  // ==========================================
  // Accepted request: refused while the dummy cycle runs
  wire logic take;
  assign take = exec_valid_in && !busy_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  chk_dummy_one: assert property (discard_prefetch_out |-> busy_out ##1 !busy_out)
    else $error("dummy cycle length wrong");
  chk_nil_skip: assert property (take && op_select_in == `OP_MEM_NIL_SKIP |=>
    discard_prefetch_out == ($past(mem_data_in) == 8'h00)
    && cycles_out == (($past(mem_data_in) == 8'h00) ? 2'h2 : 2'h1)) else $error("nil skip wrong");
  chk_dec_acc: assert property (take && op_select_in == `OP_DECREMENT_TO_ACC_SKIP |=>
    acc_out == $past(mem_data_in) - 8'h01 && !mem_write_out) else $error("decrement wrong");
  chk_set_byte: assert property (take && op_select_in == `OP_SET_BYTE |=>
    mem_write_out && mem_wdata_out == 8'hff && flags_out[3:0] == $past(flags_out[3:0]))
    else $error("set byte wrong");
  chk_set_bit: assert property (take && op_select_in == `OP_SET_BIT |=>
    mem_wdata_out == ($past(mem_data_in) | (8'h01 << $past(bit_select_in))))
    else $error("set bit wrong");
  chk_inc_wrap: assert property (take && op_select_in == `OP_INCREMENT_SKIP_ON_WRAP |=>
    mem_wdata_out == $past(mem_data_in) + 8'h01
    && discard_prefetch_out == ($past(mem_data_in) == 8'hff)) else $error("increment wrong");
  chk_bit_skip: assert property (take && op_select_in == `OP_BIT_SET_SKIP |=>
    discard_prefetch_out == $past(mem_data_in[bit_select_in])) else $error("bit set skip wrong");
  chk_bit_clear: assert property (take && op_select_in == `OP_BIT_CLEAR_SKIP |=>
    discard_prefetch_out != $past(mem_data_in[bit_select_in])) else $error("bit clear wrong");
  chk_sub_acc: assert property (take && op_select_in == `OP_MINUS_ACC |=>
    acc_out == $past(acc_out) + ~$past(mem_data_in) + 8'h01
    && flags_out[2] == (acc_out == 8'h00)) else $error("subtract wrong");
  chk_xor_mem: assert property (take && op_select_in == `OP_EXCLUSIVE_OR_INTO_MEM |=>
    mem_wdata_out == $past(acc_out ^ mem_data_in)
    && {flags_out[3], flags_out[1:0]} == $past({flags_out[3], flags_out[1:0]}))
    else $error("xor to memory wrong");
  chk_rom_final: assert property (take && op_select_in == `OP_ROM_FETCH_FINAL_PAGE |->
    rom_addr_out == {{(ROM_ADDR_WIDTH-8){1'b1}}, rom_read_pointer_in})
    else $error("final page address wrong");
endmodule // exec_group_checker

bind exec_skip_sub_xor exec_group_checker #(.ROM_ADDR_WIDTH(ROM_ADDR_WIDTH)) chk (
  .clock_in, .rst_in, .exec_valid_in, .op_select_in, .mem_data_in, .bit_select_in,
  .rom_read_pointer_in, .acc_out, .flags_out, .mem_wdata_out, .mem_write_out, .rom_addr_out,
  .discard_prefetch_out, .busy_out, .cycles_out);
`default_nettype wire

// file: testbench/exec_skip_sub_xor_tb.sv
// Self-checking bench for the execution group
`timescale 1ns/1ps
`default_nettype none
`include "exec_group_defines.vh"
module exec_skip_sub_xor_tb;
  logic        clock_in = 0, rst_in = 1, exec_valid_in = 0;
  logic        flag_time_out_in = 1, flag_power_down_in = 0;
  logic [4:0]  op_select_in = 0;
  logic [2:0]  bit_select_in = 0;
  logic [7:0]  mem_data_in = 0, literal_in = 0, rom_read_pointer_in = 8'h3c;
  logic [14:0] program_counter_in = 15'h5a00, rom_addr_out;
  logic [15:0] rom_word_in = 0;
  logic [7:0]  acc_out, mem_wdata_out, rom_upper_byte_latch_out;
  logic [5:0]  flags_out;
  logic [1:0]  cycles_out;
  logic        mem_write_out, rom_read_out, discard_prefetch_out, busy_out;
  int          bad_count = 0, check_count = 0;
  always #2.5 clock_in = ~clock_in;
  exec_skip_sub_xor dut (.clock_in, .rst_in, .exec_valid_in, .op_select_in, .mem_data_in,
    .bit_select_in, .literal_in, .rom_read_pointer_in, .program_counter_in, .rom_word_in,
    .flag_time_out_in, .flag_power_down_in, .acc_out, .flags_out, .mem_wdata_out,
    .mem_write_out, .rom_upper_byte_latch_out, .rom_addr_out, .rom_read_out,
    .discard_prefetch_out, .busy_out, .cycles_out);
  // ==========================================
  // Compare and closing tasks
  task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    check_byte(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic conclude;
    $display("mismatches %0d checks %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // One operation; x feeds literal and bit index alike
  task automatic run(input logic [4:0] op, input logic [7:0] m, input logic [7:0] x,
      input logic [7:0] ea, input logic ew, input logic [7:0] ed, input logic es,
      input logic [3:0] ef);
    @(negedge clock_in);
    op_select_in = op;
    mem_data_in = m;
    literal_in = x;
    bit_select_in = x[2:0];
    exec_valid_in = 1'b1;
    @(negedge clock_in);
    exec_valid_in = 1'b0;
    check_byte("acc", ea, acc_out);
    check_bit("write", ew, mem_write_out);
    if (ew) check_byte("wdata", ed, mem_wdata_out);
    check_bit("skip", es, discard_prefetch_out);
    check_byte("cycles", es ? 8'h02 : 8'h01, {6'h00, cycles_out});
    check_byte("flags", {4'h2, ef}, {2'h0, flags_out});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_skips;
    run(`OP_COPY_TO_ACC_NIL_SKIP, 8'h00, 8'h00, 8'h00, 0, 8'h00, 1, 4'h0);
    run(`OP_COPY_TO_ACC_NIL_SKIP, 8'h5a, 8'h00, 8'h5a, 0, 8'h00, 0, 4'h0);
    run(`OP_DECREMENT_TO_ACC_SKIP, 8'h01, 8'h00, 8'h00, 0, 8'h00, 1, 4'h0);
    run(`OP_DECREMENT_TO_ACC_SKIP, 8'h00, 8'h00, 8'hff, 0, 8'h00, 0, 4'h0);
    run(`OP_INCREMENT_SKIP_ON_WRAP, 8'hff, 8'h00, 8'hff, 1, 8'h00, 1, 4'h0);
    run(`OP_INCREMENT_TO_ACC_SKIP, 8'hff, 8'h00, 8'h00, 0, 8'h00, 1, 4'h0);
    run(`OP_INCREMENT_TO_ACC_SKIP, 8'h7f, 8'h00, 8'h80, 0, 8'h00, 0, 4'h0);
    run(`OP_MEM_NIL_SKIP, 8'h80, 8'h00, 8'h80, 0, 8'h00, 0, 4'h0);
    run(`OP_MEM_NIL_SKIP, 8'h00, 8'h00, 8'h80, 0, 8'h00, 1, 4'h0);
    run(`OP_BIT_SET_SKIP, 8'h80, 8'h07, 8'h80, 0, 8'h00, 1, 4'h0);
    run(`OP_BIT_SET_SKIP, 8'h7f, 8'h07, 8'h80, 0, 8'h00, 0, 4'h0);
    run(`OP_BIT_CLEAR_SKIP, 8'h01, 8'h00, 8'h80, 0, 8'h00, 0, 4'h0);
    run(`OP_BIT_CLEAR_SKIP, 8'hfe, 8'h00, 8'h80, 0, 8'h00, 1, 4'h0);
    run(`OP_DECREMENT_SKIP, 8'h01, 8'h00, 8'h80, 1, 8'h00, 1, 4'h0);
  endtask
  task automatic t_sub;
    run(`OP_COPY_TO_ACC_NIL_SKIP, 8'h50, 8'h00, 8'h50, 0, 8'h00, 0, 4'h0);
    run(`OP_MINUS_ACC, 8'h30, 8'h00, 8'h20, 0, 8'h00, 0, 4'h3);
    run(`OP_MINUS_IMM, 8'h00, 8'h21, 8'hff, 0, 8'h00, 0, 4'h0);
    run(`OP_COPY_TO_ACC_NIL_SKIP, 8'h80, 8'h00, 8'h80, 0, 8'h00, 0, 4'h0);
    run(`OP_MINUS_STORE_MEM, 8'h01, 8'h00, 8'h80, 1, 8'h7f, 0, 4'h9);
    run(`OP_MINUS_ACC, 8'h80, 8'h00, 8'h00, 0, 8'h00, 0, 4'h7);
  endtask
  task automatic t_set_swap;
    run(`OP_SET_BYTE, 8'h12, 8'h00, 8'h00, 1, 8'hff, 0, 4'h7);
    run(`OP_SET_BIT, 8'ha5, 8'h06, 8'h00, 1, 8'he5, 0, 4'h7);
    run(`OP_NIBBLE_EXCHANGE, 8'h3c, 8'h00, 8'h00, 1, 8'hc3, 0, 4'h7);
    run(`OP_NIBBLE_EXCHANGE_TO_ACC, 8'h12, 8'h00, 8'h21, 0, 8'h00, 0, 4'h7);
  endtask
  // Zero flag is driven both ways so a stuck flag shows
  task automatic t_xor;
    run(`OP_EXCLUSIVE_OR_IMM, 8'h00, 8'h7b, 8'h5a, 0, 8'h00, 0, 4'h3);
    run(`OP_EXCLUSIVE_OR_ACC, 8'h5a, 8'h00, 8'h00, 0, 8'h00, 0, 4'h7);
    run(`OP_EXCLUSIVE_OR_INTO_MEM, 8'h5a, 8'h00, 8'h00, 1, 8'h5a, 0, 4'h3);
  endtask
  task automatic t_table;
    for (int i = 0; i < 2; i++) begin
      @(negedge clock_in);
      op_select_in = i ? `OP_ROM_FETCH_FINAL_PAGE : `OP_ROM_FETCH_CURRENT_PAGE;
      rom_word_in = i ? 16'h1234 : 16'hbeef;
      exec_valid_in = 1'b1;
      #1 check_byte("page", i ? 8'h7f : 8'h5a, {1'b0, rom_addr_out[14:8]});
      check_byte("pointer", 8'h3c, rom_addr_out[7:0]);
      @(negedge clock_in);
      exec_valid_in = 1'b0;
      check_byte("low", i ? 8'h34 : 8'hef, mem_wdata_out);
      check_byte("high", i ? 8'h12 : 8'hbe, rom_upper_byte_latch_out);
      check_bit("read", 1'b1, mem_write_out & rom_read_out);
      check_byte("flags", 8'h23, {2'h0, flags_out});
    end
  endtask
  // Request held through the dummy cycle must wait one cycle
  task automatic t_busy;
    @(negedge clock_in);
    op_select_in = `OP_MEM_NIL_SKIP;
    mem_data_in = 8'h00;
    exec_valid_in = 1'b1;
    @(negedge clock_in);
    check_bit("busy", 1'b1, busy_out & discard_prefetch_out);
    op_select_in = `OP_SET_BYTE;
    @(negedge clock_in);
    check_bit("refused", 1'b0, mem_write_out | busy_out);
    @(negedge clock_in);
    exec_valid_in = 1'b0;
    check_bit("taken", 1'b1, mem_write_out);
    check_byte("set data", 8'hff, mem_wdata_out);
  endtask
  initial begin
    repeat (2) @(negedge clock_in);
    check_byte("reset acc", 8'h00, acc_out);
    rst_in = 1'b0;
    t_skips;
    t_sub;
    t_set_swap;
    t_xor;
    t_table;
    t_busy;
    conclude;
  end
  // Whole run is about 64 cycles
  initial begin
    repeat (2000) @(posedge clock_in);
    bad_count++;
    conclude;
  end
endmodule // exec_skip_sub_xor_tb
`default_nettype wire
